// *** hdl/qdog_chan_corr.sv ***
// One channel of gain and offset correction, purely combinational.
// Assumes the caller registers the result.
module qdog_chan_corr import qdog_pkg::*; (
   input wire logic signed [SAMPLE_W-1:0] sample,
   input wire logic [GAIN_W-1:0] gain,
   input wire logic signed [OFFSET_W-1:0] offset,
   output logic signed [SAMPLE_W-1:0] corrected
);
   localparam int PROD_W = SAMPLE_W + GAIN_W + 1;

   logic signed [PROD_W-1:0] product;
   logic signed [PROD_W-GAIN_FRAC-1:0] scaled;
   logic signed [SAMPLE_W+2:0] sum;

   // Binary point sits between gain bits 9 and 10
   assign product = sample * $signed({1'b0, gain});
   assign scaled = product[PROD_W-1:GAIN_FRAC];
   assign sum = 19'(scaled) + 19'(offset);

   // Saturate rather than wrap: a wrap would flip full scale
   always_comb begin
      if (sum > SAMPLE_MAX) begin
         corrected = SAMPLE_MAX[SAMPLE_W-1:0];
      end else if (sum < SAMPLE_MIN) begin
         corrected = SAMPLE_MIN[SAMPLE_W-1:0];
      end else begin
         corrected = sum[SAMPLE_W-1:0];
      end
   end

endmodule : qdog_chan_corr

// *** hdl/qdog_fifo.sv ***
// Sample FIFO with valid/ready on both sides.
// Assumes one clock; the drain side may stall at will.
module qdog_fifo import qdog_pkg::*; #(
   parameter int WIDTH = QUAD_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W:0] wr_ptr;
   logic [PTR_W:0] rd_ptr;
   logic push;
   logic pop;

   // Extra pointer bit tells full from empty
   assign out_valid = wr_ptr != rd_ptr;
   assign in_ready = (wr_ptr[PTR_W] == rd_ptr[PTR_W]) || (wr_ptr[PTR_W-1:0] != rd_ptr[PTR_W-1:0]);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr[PTR_W-1:0]];

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr[PTR_W-1:0]] <= in_data;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wr_ptr <= '0;
      end else if (push) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rd_ptr <= '0;
      end else if (pop) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end

endmodule : qdog_fifo

// *** hdl/qdog_pkg.sv ***
// Constants, carriers and helpers for the offset/gain correction register bank.
// Assumes a single converter clock domain and a 16-bit plain register port.
package qdog_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int SAMPLE_W = 16;
   localparam int OFFSET_W = 13;
   localparam int GAIN_W = 11;
   localparam int GAIN_FRAC = 10;
   localparam int MIX_W = 4;
   localparam int MIX_LSB = 12;
   localparam int STEP_W = 3;
   localparam int FIFO_DEPTH = 16;

   // Register offsets
   localparam logic [ADDR_W-1:0] ADDR_C_OFFSET = 8'h0A;
   localparam logic [ADDR_W-1:0] ADDR_D_OFFSET = 8'h0B;
   localparam logic [ADDR_W-1:0] ADDR_A_GAIN = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_MIX_B_GAIN = 8'h0D;
   localparam logic [ADDR_W-1:0] ADDR_C_GAIN = 8'h0E;

   // Reset values
   localparam logic [OFFSET_W-1:0] RST_OFFSET = 13'h0000;
   localparam logic [GAIN_W-1:0] RST_GAIN = 11'h0400;
   localparam logic [MIX_W-1:0] RST_MIX = 4'h0;
   localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

   // Coarse mixer field bits and their shift in Fs/8 units
   localparam int MIX_FS8_BIT = 3;
   localparam int MIX_FS4_BIT = 2;
   localparam int MIX_FS2_BIT = 1;
   localparam int MIX_NFS4_BIT = 0;
   localparam logic [STEP_W-1:0] STEP_NONE = 3'h0;
   localparam logic [STEP_W-1:0] STEP_FS8 = 3'h1;
   localparam logic [STEP_W-1:0] STEP_FS4 = 3'h2;
   localparam logic [STEP_W-1:0] STEP_FS2 = 3'h4;
   localparam logic [STEP_W-1:0] STEP_NFS4 = 3'h6;

   localparam logic signed [SAMPLE_W+2:0] SAMPLE_MAX = 19'sh0_7FFF;
   localparam logic signed [SAMPLE_W+2:0] SAMPLE_MIN = -19'sh0_8000;

   typedef struct packed {
      logic signed [SAMPLE_W-1:0] a;
      logic signed [SAMPLE_W-1:0] b;
      logic signed [SAMPLE_W-1:0] c;
      logic signed [SAMPLE_W-1:0] d;
   } qdog_quad_t;

   localparam int QUAD_W = $bits(qdog_quad_t);

   typedef struct packed {
      logic signed [OFFSET_W-1:0] c;
      logic signed [OFFSET_W-1:0] d;
   } qdog_offsets_t;

   // Shifts add modulo 8, so any mix of bits lands on n x Fs/8
   function automatic logic [STEP_W-1:0] qdog_mix_step(input logic [MIX_W-1:0] f);
      logic [STEP_W-1:0] s;
      s = STEP_NONE;
      if (f[MIX_FS8_BIT]) s = s + STEP_FS8;
      if (f[MIX_FS4_BIT]) s = s + STEP_FS4;
      if (f[MIX_FS2_BIT]) s = s + STEP_FS2;
      if (f[MIX_NFS4_BIT]) s = s + STEP_NFS4;
      return s;
   endfunction : qdog_mix_step

endpackage : qdog_pkg

// *** hdl/qdog_regs.sv ***
// Offset/gain correction register bank with the correction datapath.
// Assumes a plain register port and an upstream sample source and a
// downstream converter both on mclk.
//
// The plain strobed port was decided locally.

//////////////////////////////////////////////////////////////////////////////
// Contract
// - Hold 13-bit channel C offset word
// - Hold 13-bit channel D offset word
// - C offset write with auto-sync loads both
// - D offset write alone leaves active unchanged
// - Hold 11-bit unsigned gains for A, B, C
// - Gain binary point below bit 10; 0x400 unity
// - 4-bit mixer select field, resets to zero
// - Combined mixer bits give n x Fs/8
module qdog_regs import qdog_pkg::*; (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic auto_sync_en,
   input wire logic ext_sync,
   input wire logic in_valid,
   output logic in_ready,
   input wire qdog_quad_t in_samples,
   output logic out_valid,
   input wire logic out_ready,
   output qdog_quad_t out_samples,
   output logic [STEP_W-1:0] coarse_mix_step
);

   //////////////////////////////////////////////////////////////////////////
   // Register storage
   logic [OFFSET_W-1:0] chan_c_offset_word;
   logic [OFFSET_W-1:0] chan_d_offset_word;
   logic [GAIN_W-1:0] chan_a_gain_word;
   logic [GAIN_W-1:0] chan_b_gain_word;
   logic [GAIN_W-1:0] chan_c_gain_word;
   logic [MIX_W-1:0] coarse_mix_field;
   qdog_offsets_t active_offset;
   qdog_quad_t fifo_samples;
   qdog_quad_t next_out_samples;
   logic fifo_valid;
   logic fifo_ready;
   logic pop;
   logic wr_c_offset;
   logic wr_d_offset;
   logic wr_a_gain;
   logic wr_mix_b_gain;
   logic wr_c_gain;
   logic auto_sync;

   assign wr_c_offset = reg_wr && (reg_addr == ADDR_C_OFFSET);
   assign wr_d_offset = reg_wr && (reg_addr == ADDR_D_OFFSET);
   assign wr_a_gain = reg_wr && (reg_addr == ADDR_A_GAIN);
   assign wr_mix_b_gain = reg_wr && (reg_addr == ADDR_MIX_B_GAIN);
   assign wr_c_gain = reg_wr && (reg_addr == ADDR_C_GAIN);
   assign auto_sync = wr_c_offset && auto_sync_en;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         chan_c_offset_word <= RST_OFFSET;
      end else if (wr_c_offset) begin
         chan_c_offset_word <= reg_wdata[OFFSET_W-1:0];
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         chan_d_offset_word <= RST_OFFSET;
      end else if (wr_d_offset) begin
         chan_d_offset_word <= reg_wdata[OFFSET_W-1:0];
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         chan_a_gain_word <= RST_GAIN;
      end else if (wr_a_gain) begin
         chan_a_gain_word <= reg_wdata[GAIN_W-1:0];
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         chan_b_gain_word <= RST_GAIN;
         coarse_mix_field <= RST_MIX;
      end else if (wr_mix_b_gain) begin
         chan_b_gain_word <= reg_wdata[GAIN_W-1:0];
         coarse_mix_field <= reg_wdata[MIX_LSB+MIX_W-1:MIX_LSB];
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         chan_c_gain_word <= RST_GAIN;
      end else if (wr_c_gain) begin
         chan_c_gain_word <= reg_wdata[GAIN_W-1:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Synchronised offset load
   // The D word only reaches the datapath here, so the host must stage D
   // before writing C. An external sync loads whatever is staged.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         active_offset <= '0;
      end else if (auto_sync) begin
         active_offset.c <= reg_wdata[OFFSET_W-1:0];
         active_offset.d <= chan_d_offset_word;
      end else if (ext_sync) begin
         active_offset.c <= chan_c_offset_word;
         active_offset.d <= chan_d_offset_word;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Coarse mixer step
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         coarse_mix_step <= STEP_NONE;
      end else begin
         coarse_mix_step <= qdog_mix_step(coarse_mix_field);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Read port; reserved bits read as zero
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         reg_rdata <= READ_ZERO;
      end else if (reg_rd) begin
         reg_rdata <= READ_ZERO;
         case (reg_addr)
            ADDR_C_OFFSET: begin
               reg_rdata[OFFSET_W-1:0] <= chan_c_offset_word;
            end
            ADDR_D_OFFSET: begin
               reg_rdata[OFFSET_W-1:0] <= chan_d_offset_word;
            end
            ADDR_A_GAIN: begin
               reg_rdata[GAIN_W-1:0] <= chan_a_gain_word;
            end
            ADDR_MIX_B_GAIN: begin
               reg_rdata[MIX_LSB+MIX_W-1:MIX_LSB] <= coarse_mix_field;
               reg_rdata[GAIN_W-1:0] <= chan_b_gain_word;
            end
            ADDR_C_GAIN: begin
               reg_rdata[GAIN_W-1:0] <= chan_c_gain_word;
            end
            default: begin
               reg_rdata <= READ_ZERO;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Sample path: FIFO, correction, output register
   qdog_fifo #(
      .WIDTH(QUAD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .reset(reset),
      .in_valid(in_valid),
      .in_ready(in_ready),
      .in_data(in_samples),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_samples)
   );

   // Output stage drains the FIFO only when it can hand the word on
   assign fifo_ready = !out_valid || out_ready;
   assign pop = fifo_valid && fifo_ready;

   // Channel D gain lives elsewhere; unity here
   qdog_chan_corr u_corr_a (
      .sample(fifo_samples.a),
      .gain(chan_a_gain_word),
      .offset(OFFSET_W'(0)),
      .corrected(next_out_samples.a)
   );

   qdog_chan_corr u_corr_b (
      .sample(fifo_samples.b),
      .gain(chan_b_gain_word),
      .offset(OFFSET_W'(0)),
      .corrected(next_out_samples.b)
   );

   qdog_chan_corr u_corr_c (
      .sample(fifo_samples.c),
      .gain(chan_c_gain_word),
      .offset(active_offset.c),
      .corrected(next_out_samples.c)
   );

   qdog_chan_corr u_corr_d (
      .sample(fifo_samples.d),
      .gain(RST_GAIN),
      .offset(active_offset.d),
      .corrected(next_out_samples.d)
   );

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         out_samples <= '0;
      end else if (pop) begin
         out_samples <= next_out_samples;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         out_valid <= 1'b0;
      end else if (pop) begin
         out_valid <= 1'b1;
      end else if (out_ready) begin
         out_valid <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   logic small_c;
   assign small_c = (fifo_samples.c < 16'sh3FFF) && (fifo_samples.c > -16'sh3FFF);

   a_offc_store: assert property (
      wr_c_offset |=> chan_c_offset_word == $past(reg_wdata[OFFSET_W-1:0]))
      else $error("channel C offset not stored");

   a_offd_store: assert property (
      wr_d_offset ##1 !reg_wr ##1 (reg_rd && reg_addr == ADDR_D_OFFSET)
      |=> reg_rdata == {3'h0, $past(reg_wdata[OFFSET_W-1:0], 3)})
      else $error("channel D offset readback wrong");

   a_sync_load: assert property (
      auto_sync |=> active_offset.c == $past(reg_wdata[OFFSET_W-1:0])
      && active_offset.d == chan_d_offset_word)
      else $error("auto-sync did not load both offsets");

   a_d_no_effect: assert property (
      wr_d_offset && !ext_sync |=> $stable(active_offset))
      else $error("D write changed active offset");

   a_gain_store: assert property (
      wr_a_gain ##1 (!wr_a_gain)[*2] |-> chan_a_gain_word == $past(reg_wdata[GAIN_W-1:0], 2))
      else $error("channel A gain not held");

   a_unity_pass: assert property (
      pop && chan_b_gain_word == RST_GAIN |=> out_samples.b == $past(fifo_samples.b))
      else $error("unity gain altered channel B");

   a_mix_read: assert property (
      reg_rd && reg_addr == ADDR_MIX_B_GAIN
      |=> reg_rdata[MIX_LSB+MIX_W-1:MIX_LSB] == $past(coarse_mix_field))
      else $error("mixer field readback wrong");

   a_mix_step: assert property (
      wr_mix_b_gain ##1 !wr_mix_b_gain
      |=> coarse_mix_step == qdog_mix_step($past(reg_wdata[MIX_LSB+MIX_W-1:MIX_LSB], 2)))
      else $error("mixer step not n x Fs/8 sum");

   a_offset_add: assert property (
      pop && chan_c_gain_word == RST_GAIN && small_c
      |=> out_samples.c == $past(fifo_samples.c) + 16'($signed($past(active_offset.c))))
      else $error("channel C offset not applied");

   a_hold_stall: assert property (
      out_valid && !out_ready |=> out_valid && $stable(out_samples))
      else $error("output dropped while stalled");

   a_unmapped_zero: assert property (
      reg_rd && reg_addr > ADDR_C_GAIN |=> reg_rdata == READ_ZERO)
      else $error("unmapped read not zero");

   // Sync load, storage, hold, readback and output-valid drop checks
   a_ext_load: assert property (
      ext_sync && !auto_sync |=> active_offset.c == $past(chan_c_offset_word)
      && active_offset.d == $past(chan_d_offset_word))
      else $error("external sync did not load staged offsets");

   a_c_no_sync: assert property (
      wr_c_offset && !auto_sync_en && !ext_sync |=> $stable(active_offset))
      else $error("C write without auto-sync changed active offset");

   a_gainb_store: assert property (
      wr_mix_b_gain |=> chan_b_gain_word == $past(reg_wdata[GAIN_W-1:0]))
      else $error("channel B gain not stored");

   a_gainc_store: assert property (
      wr_c_gain |=> chan_c_gain_word == $past(reg_wdata[GAIN_W-1:0]))
      else $error("channel C gain not stored");

   a_mix_store: assert property (
      wr_mix_b_gain |=> coarse_mix_field == $past(reg_wdata[MIX_LSB+MIX_W-1:MIX_LSB]))
      else $error("mixer field not stored");

   a_offc_read: assert property (
      reg_rd && reg_addr == ADDR_C_OFFSET |=> reg_rdata == {3'h0, $past(chan_c_offset_word)})
      else $error("channel C offset readback wrong");

   a_gainc_read: assert property (
      reg_rd && reg_addr == ADDR_C_GAIN |=> reg_rdata == {5'h00, $past(chan_c_gain_word)})
      else $error("channel C gain readback wrong");

   a_rdata_hold: assert property (
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");

   a_out_drop: assert property (
      out_valid && out_ready && !pop |=> !out_valid)
      else $error("output valid stayed after last word taken");

   a_mix_hold: assert property (
      !wr_mix_b_gain |=> $stable(coarse_mix_field))
      else $error("mixer field changed without a write");

   a_offd_hold: assert property (
      !wr_d_offset |=> $stable(chan_d_offset_word))
      else $error("channel D offset changed without a write");

   a_active_hold: assert property (
      !auto_sync && !ext_sync |=> $stable(active_offset))
      else $error("active offset changed without a sync");

   c_auto_sync: cover property (wr_d_offset ##[1:4] auto_sync);
   c_fifo_full: cover property (!in_ready ##1 pop);
   c_mix_all: cover property (coarse_mix_field == 4'hF);
   c_stream: cover property (pop [*4]);

endmodule : qdog_regs

// *** tb/qdog_host.sv ***
// Host model: drives the plain register port of the correction bank.
// Assumes one bench process calls its tasks; strobes change after rising edges.
module qdog_host import qdog_pkg::*; (
   input wire logic mclk,
   output logic [ADDR_W-1:0] reg_addr,
   output logic [DATA_W-1:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      d = reg_rdata;
   endtask : rd

   // D goes first so the C write loads a complete pair; reserved bits stay zero
   task automatic set_offsets(input logic [OFFSET_W-1:0] c, input logic [OFFSET_W-1:0] d);
      wr(ADDR_D_OFFSET, {3'b000, d});
      wr(ADDR_C_OFFSET, {3'b000, c});
   endtask : set_offsets
endmodule : qdog_host

// *** tb/qdog_regs_tb.sv ***
// Self-checking bench for the offset/gain correction bank.
// Assumes the host model on the register port and the bench as sample source and sink.
module qdog_regs_tb import qdog_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, r;
   logic reg_wr, reg_rd, in_ready, out_valid;
   logic auto_sync_en = 1'b0;
   logic ext_sync = 1'b0;
   logic in_valid = 1'b0;
   logic out_ready = 1'b0;
   qdog_quad_t in_samples = '0;
   qdog_quad_t out_samples;
   logic [STEP_W-1:0] coarse_mix_step;
   logic [GAIN_W-1:0] ga = 11'h400, gb = 11'h400, gc = 11'h400;
   logic signed [OFFSET_W-1:0] oc = '0, od = '0;
   int fail_count = 0;
   int n_checks = 0;

   initial forever #2 mclk = ~mclk;

   qdog_regs DUT (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .auto_sync_en(auto_sync_en),
      .ext_sync(ext_sync), .in_valid(in_valid), .in_ready(in_ready), .in_samples(in_samples),
      .out_valid(out_valid), .out_ready(out_ready), .out_samples(out_samples),
      .coarse_mix_step(coarse_mix_step));

   qdog_host u_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   //////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic timeout;
      fail_count++;
      $display("[ERR] %0t handshake never came", $time);
      wrap_up();
   endtask : timeout

   // Saturating model of one channel: gain has ten fraction bits
   function automatic logic [15:0] corr(input logic signed [15:0] s, input logic [10:0] g,
         input logic signed [12:0] o);
      longint v;
      v = ((longint'(s) * longint'({1'b0, g})) >>> 10) + longint'(o);
      if (v > 32767) v = 32767;
      if (v < -32768) v = -32768;
      return v[15:0];
   endfunction : corr

   function automatic qdog_quad_t expw(input qdog_quad_t w);
      expw.a = corr(w.a, ga, 13'h0000);
      expw.b = corr(w.b, gb, 13'h0000);
      expw.c = corr(w.c, gc, oc);
      expw.d = corr(w.d, 11'h400, od);
   endfunction : expw

   function automatic qdog_quad_t mk(input int i);
      return qdog_quad_t'({16'(i * 100), 16'(-i * 50), 16'(i * 300), 16'(i)});
   endfunction : mk

   task automatic push(input qdog_quad_t w);
      int k;
      in_valid <= 1'b1;
      in_samples <= w;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (in_ready !== 1'b1 && k < 50);
      if (in_ready !== 1'b1) timeout();
   endtask : push

   task automatic pull(output qdog_quad_t w);
      int k;
      out_ready <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (out_valid !== 1'b1 && k < 50);
      if (out_valid !== 1'b1) timeout();
      w = out_samples;
   endtask : pull

   task automatic xfer(input qdog_quad_t w);
      qdog_quad_t got;
      push(w);
      in_valid <= 1'b0;
      pull(got);
      out_ready <= 1'b0;
      check(got, expw(w));
   endtask : xfer

   //////////////////////////////////////////////////////////////////////////////
   task automatic s_reset;
      logic [ADDR_W-1:0] a [6] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F};
      logic [DATA_W-1:0] e [6] = '{16'h0000, 16'h0000, 16'h0400, 16'h0400, 16'h0400, 16'h0000};
      for (int i = 0; i < 6; i++) begin
         u_host.rd(a[i], r);
         check(64'(r), 64'(e[i]));
      end
      check(64'(coarse_mix_step), 64'h0);
   endtask : s_reset

   // All ones written; only the documented fields may read back
   task automatic s_fields;
      logic [DATA_W-1:0] e [5] = '{16'h1FFF, 16'h1FFF, 16'h07FF, 16'hF7FF, 16'h07FF};
      for (int i = 0; i < 5; i++) begin
         u_host.wr(8'(8'h0A + i), 16'hFFFF);
         u_host.rd(8'(8'h0A + i), r);
         check(64'(r), 64'(e[i]));
      end
   endtask : s_fields

   task automatic s_mix;
      logic [MIX_W-1:0] f;
      for (int i = 0; i < 16; i++) begin
         f = 4'(i);
         u_host.wr(ADDR_MIX_B_GAIN, {f, 1'b0, 11'h400});
         repeat (2) @(posedge mclk);
         check(64'(coarse_mix_step), 64'(3'(f[3] * 1 + f[2] * 2 + f[1] * 4 + f[0] * 6)));
         u_host.rd(ADDR_MIX_B_GAIN, r);
         check(64'(r), 64'({f, 12'h400}));
      end
   endtask : s_mix

   task automatic s_sync;
      qdog_quad_t w1, w2;
      w1 = qdog_quad_t'({16'sd1000, -16'sd2000, 16'sd20000, 16'sd300});
      w2 = qdog_quad_t'({16'sd1000, -16'sd2000, 16'sd1000, 16'sd300});
      ga = 11'h200;
      gb = 11'h600;
      gc = 11'h7FF;
      u_host.wr(ADDR_A_GAIN, {5'h00, ga});
      u_host.wr(ADDR_MIX_B_GAIN, {5'h00, gb});
      u_host.wr(ADDR_C_GAIN, {5'h00, gc});
      auto_sync_en <= 1'b1;
      oc = 13'sd100;
      od = -13'sd100;
      u_host.set_offsets(oc, od);
      xfer(w1);
      u_host.wr(ADDR_D_OFFSET, 16'h0010);
      xfer(w2);
      auto_sync_en <= 1'b0;
      u_host.wr(ADDR_C_OFFSET, 16'h0000);
      xfer(w2);
      ext_sync <= 1'b1;
      @(posedge mclk);
      ext_sync <= 1'b0;
      oc = 13'sd0;
      od = 13'sd16;
      xfer(w2);
   endtask : s_sync

   // Sink stalls until the buffer refuses, then drains in order
   task automatic s_fifo;
      qdog_quad_t got;
      int n;
      n = 0;
      // Unity B and C gains with fresh offsets exercise the pass-through checks
      gb = 11'h400;
      gc = 11'h400;
      oc = -13'sd77;
      od = 13'sd5;
      u_host.wr(ADDR_MIX_B_GAIN, {5'h00, gb});
      u_host.wr(ADDR_C_GAIN, {5'h00, gc});
      auto_sync_en <= 1'b1;
      u_host.set_offsets(oc, od);
      in_valid <= 1'b1;
      in_samples <= mk(0);
      for (int k = 0; k < 40 && in_ready !== 1'b0; k++) begin
         @(posedge mclk);
         if (in_ready === 1'b1) begin
            n++;
            in_samples <= mk(n);
         end
      end
      in_valid <= 1'b0;
      check(64'(n), 64'(FIFO_DEPTH + 1));
      for (int i = 0; i < n; i++) begin
         pull(got);
         check(got, expw(mk(i)));
      end
      out_ready <= 1'b0;
      @(posedge mclk);
      check(64'(out_valid), 64'h0);
   endtask : s_fifo

   initial begin
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      s_reset();
      s_fields();
      s_mix();
      s_sync();
      s_fifo();
      wrap_up();
   end
endmodule : qdog_regs_tb
